// File: common/pmic_discharge_defines.vh
// Purpose: Constants for the discharge and soft-reset control block
// Assumes: 8-bit registers reached through a byte-wide register port
// Notes:   Offsets, field positions, reset values and codes
`ifndef PMIC_DISCHARGE_DEFINES_VH
`define PMIC_DISCHARGE_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_DISCHARGE_CFG      8'h0f
`define ADDR_SOFT_RESET_POLICY  8'h10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_DISCHARGE_CFG       8'h3f
`define RST_SOFT_RESET_POLICY   8'h00
`define RST_FAULT_KEEP_RUNNING  1'b0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_STEP_DOWN_LOAD      7
`define BIT_STEP_UP_LOAD        6
`define BIT_STEP_UP_PULLDOWN    1
`define BIT_STEP_DOWN_PULLDOWN  0
`define LSB_LINREG_PULLDOWN     2
`define MSB_LINREG_PULLDOWN     5
`define LSB_SOFT_RESET          3
`define MSB_SOFT_RESET          6
`define BIT_FAULT_KEEP_RUNNING  0

// ----------------------------------------
// Codes
// ----------------------------------------
`define SOFT_RESET_CODE         4'hb
`define SEQ_CMD_SHUTDOWN        2'h2

`endif

// File: hdl/pmic_discharge_reset_control.v
// Purpose: Discharge, internal-load, soft-reset and fault policy control
// Assumes: Serial front end delivers one-cycle byte writes and reads
// Notes:   All outputs registered; converter enables come from elsewhere
`timescale 1ns/10ps
`include "pmic_discharge_defines.vh"

module pmic_discharge_reset_control
(
    input  wire       clk_in,
    input  wire       rst_n_in,
    input  wire       wr_en_in,
    input  wire       rd_en_in,
    input  wire [7:0] addr_in,
    input  wire [7:0] wdata_in,
    input  wire       hw_enable_pin_in,
    input  wire       step_up_enable_pin_in,
    input  wire       step_down_on_bit_in,
    input  wire       step_up_on_bit_in,
    input  wire [3:0] linreg_on_in,
    input  wire [1:0] sequencer_command_in,
    input  wire       sequencer_command_wr_in,
    input  wire       power_up_done_in,
    input  wire [5:0] ovp_in,
    input  wire [5:0] uvp_in,
    input  wire [5:0] ocp_in,
    input  wire [1:0] hard_short_in,
    input  wire       pfm_step_down_in,
    input  wire       pfm_step_up_in,
    output reg  [7:0] rdata_out,
    output reg        rvalid_out,
    output reg  [5:0] pulldown_out,
    output reg        step_down_load_out,
    output reg        step_up_load_out,
    output reg  [5:0] fault_off_out,
    output reg        soft_reset_pulse_out
);

    // Output order everywhere: [0] buck, [1] boost, [5:2] linear regs 1..4
    reg  [7:0] discharge_cfg;
    reg        fault_keep_running;
    reg        seq_shutdown;
    reg        soft_reset_req;
    reg  [5:0] next_pulldown;
    reg  [5:0] next_fault_off;
    reg  [5:0] drive_on;
    reg  [5:0] latched_off;
    wire [5:0] fault_any;
    wire       sr_write;
    integer    i;
    integer    j;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Write strobe aimed at one register offset
    function reg_write_hit;
        input       strobe;
        input [7:0] addr;
        input [7:0] offset;
        begin
            reg_write_hit = strobe && (addr == offset);
        end
    endfunction

    // Buck and linear regulators share the enable pin and the sequencer
    function common_rail_on;
        input pin;
        input own_bit;
        input shutdown;
        begin
            common_rail_on = pin && own_bit && !shutdown;
        end
    endfunction

    // Any of the three fault kinds counts alike for shutdown
    assign fault_any = ovp_in | uvp_in | ocp_in;
    assign sr_write  = reg_write_hit(wr_en_in, addr_in,
                                     `ADDR_SOFT_RESET_POLICY);

    // ----------------------------------------
    // Register writes and soft reset
    // ----------------------------------------
    // The soft-reset field is never stored: a matching code raises a one
    // cycle request, so the field reads back zero once the reset has run.
    // A write that lands while the request is live is lost to the reset.
    always @(posedge clk_in)
    begin
        if (!rst_n_in || soft_reset_req)
        begin
            discharge_cfg      <= `RST_DISCHARGE_CFG;
            fault_keep_running <= `RST_FAULT_KEEP_RUNNING;
            soft_reset_req     <= 1'b0;
        end
        else
        begin
            // Writes to any other offset are dropped
            if (reg_write_hit(wr_en_in, addr_in, `ADDR_DISCHARGE_CFG))
                discharge_cfg <= wdata_in;
            if (sr_write)
            begin
                // A reset code wins over the policy bit in the same write
                if (wdata_in[`MSB_SOFT_RESET:`LSB_SOFT_RESET]
                    == `SOFT_RESET_CODE)
                    soft_reset_req <= 1'b1;
                else
                    fault_keep_running <=
                        wdata_in[`BIT_FAULT_KEEP_RUNNING];
            end
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Reads have no side effects; unmapped offsets return zero
    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            rdata_out  <= 8'h00;
            rvalid_out <= 1'b0;
        end
        else
        begin
            rvalid_out <= rd_en_in;
            if (rd_en_in)
            begin
                case (addr_in)
                    `ADDR_DISCHARGE_CFG:
                        rdata_out <= discharge_cfg;
                    `ADDR_SOFT_RESET_POLICY:
                        rdata_out <= {7'h00, fault_keep_running};
                    default:
                        rdata_out <= 8'h00;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Sequenced shutdown and fault latching
    // ----------------------------------------
    // Shutdown state holds until a power-up sequence completes.
    // Fault shutdowns latch until the converter is disabled with its fault gone,
    // else an output would chatter as the fault clears under its own discharge.
    always @(posedge clk_in)
    begin
        if (!rst_n_in || soft_reset_req)
        begin
            seq_shutdown <= 1'b0;
            latched_off  <= 6'h00;
        end
        else
        begin
            if (sequencer_command_wr_in &&
                sequencer_command_in == `SEQ_CMD_SHUTDOWN)
                seq_shutdown <= 1'b1;
            else if (power_up_done_in)
                seq_shutdown <= 1'b0;
            for (i = 0; i < 6; i = i + 1)
            begin
                // A new fault wins over the release in the same cycle
                if (next_fault_off[i])
                    latched_off[i] <= 1'b1;
                else if (!drive_on[i] && !fault_any[i])
                    latched_off[i] <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Enable and discharge decisions
    // ----------------------------------------
    always @*
    begin
        drive_on[0] = common_rail_on(hw_enable_pin_in, step_down_on_bit_in,
                                     seq_shutdown);
        // Boost ignores the sequencer and the common enable pin
        drive_on[1] = step_up_enable_pin_in && step_up_on_bit_in;
        for (j = 0; j < 4; j = j + 1)
            drive_on[j+2] = common_rail_on(hw_enable_pin_in, linreg_on_in[j],
                                           seq_shutdown);
        next_fault_off = fault_any & {6{~fault_keep_running}};
        // Hard shorts on the switchers override the keep-running policy
        next_fault_off[1:0] = next_fault_off[1:0] | hard_short_in;
        for (j = 0; j < 6; j = j + 1)
        begin
            // Over-voltage discharges when the pull-down bit is set; with that bit set the output is also discharged
            // whenever not driven, and released once driven with no over-voltage or latched fault
            next_pulldown[j] = discharge_cfg[j] &&
                (!drive_on[j] || ovp_in[j] || latched_off[j]);
        end
        next_pulldown = next_pulldown & discharge_cfg[5:0];
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    // Every output leaves a flop so the power stages never see a glitch
    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            pulldown_out         <= 6'h00;
            step_down_load_out   <= 1'b0;
            step_up_load_out     <= 1'b0;
            fault_off_out        <= 6'h00;
            soft_reset_pulse_out <= 1'b0;
        end
        else
        begin
            pulldown_out       <= next_pulldown;
            step_down_load_out <= discharge_cfg[`BIT_STEP_DOWN_LOAD]
                                  && pfm_step_down_in;
            step_up_load_out   <= discharge_cfg[`BIT_STEP_UP_LOAD]
                                  && pfm_step_up_in;
            fault_off_out        <= next_fault_off | latched_off;
            soft_reset_pulse_out <= soft_reset_req;
        end
    end

endmodule // pmic_discharge_reset_control

// File: verification/host_model.sv
// Purpose: Host on the byte register port
// Assumes: One-cycle strobes, read data a cycle later
// Notes:   Released address and data show inverted values
`timescale 1ns/10ps
module host_model
(
    input  wire [7:0] rdata_in,
    input  wire       clk_in,
    output reg        wr_en_out = 1'b0,
    output reg        rd_en_out = 1'b0,
    output reg  [7:0] addr_out  = 8'h00,
    output reg  [7:0] wdata_out = 8'h00
);
    task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q);
        @(posedge clk_in);
        addr_out <= a; wdata_out <= d; wr_en_out <= w; rd_en_out <= !w;
        @(posedge clk_in);
        wr_en_out <= 1'b0; rd_en_out <= 1'b0; addr_out <= ~a; wdata_out <= ~d;
        #1 q = rdata_in;
    endtask
endmodule // host_model

// File: verification/discharge_checker_asserts.sv
// Purpose: Port checker for the discharge block
// Assumes: Registered outputs
// Notes:   Bound to the block
`timescale 1ns/10ps
module discharge_checker
(
    input wire       clk_in,
    input wire       rst_n_in,
    input wire       wr_en_in,
    input wire       rd_en_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire       step_up_enable_pin_in,
    input wire       step_up_on_bit_in,
    input wire [5:0] ovp_in,
    input wire [1:0] hard_short_in,
    input wire       pfm_step_down_in,
    input wire       pfm_step_up_in,
    input wire [7:0] rdata_out,
    input wire       rvalid_out,
    input wire [5:0] pulldown_out,
    input wire       step_down_load_out,
    input wire       step_up_load_out,
    input wire [5:0] fault_off_out,
    input wire       soft_reset_pulse_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_sr;
        wr_en_in && addr_in == 8'h10;
    endsequence
    sequence s_pls;
        ##2 soft_reset_pulse_out ##1 !soft_reset_pulse_out;
    endsequence
    property p_sr; s_sr ##0 wdata_in[6:3] == 4'hb |-> s_pls; endproperty
    property p_ign;
        s_sr ##0 wdata_in[6:3] != 4'hb |-> ##2 !soft_reset_pulse_out;
    endproperty
    property p_rv; rd_en_in |=> rvalid_out; endproperty
    property p_map;
        rd_en_in && addr_in != 8'h0f && addr_in != 8'h10
            |=> rdata_out == 8'h00;
    endproperty
    property p_sh; hard_short_in[0] |-> ##[1:2] fault_off_out[0]; endproperty
    property p_bst;
        (step_up_enable_pin_in && step_up_on_bit_in && !ovp_in[1]
            && !fault_off_out[1]) [*2] |=> !pulldown_out[1];
    endproperty
    property p_ldn; !pfm_step_down_in |=> !step_down_load_out; endproperty
    property p_lup; !pfm_step_up_in |=> !step_up_load_out; endproperty
    a_sr: assert property (p_sr) else $error("bad reset pulse");
    a_ign: assert property (p_ign) else $error("bad pulse");
    a_rv: assert property (p_rv) else $error("no read valid");
    a_map: assert property (p_map) else $error("bad unmapped read");
    a_sh: assert property (p_sh) else $error("short kept on");
    a_bst: assert property (p_bst) else $error("pull-down on");
    a_ldn: assert property (p_ldn) else $error("load on");
    a_lup: assert property (p_lup) else $error("load on");
endmodule // discharge_checker
bind pmic_discharge_reset_control discharge_checker discharge_checker_inst (.*);

// File: verification/pmic_discharge_reset_control_tb.sv
// Purpose: Bench for the discharge block
// Assumes: Host model owns the register port
// Notes:   Outputs judged three edges after a change
`timescale 1ns/10ps
module pmic_discharge_reset_control_tb;
    reg        clk_in = 1'b0, rst_n_in = 1'b0, sequencer_command_wr_in = 1'b0;
    reg        hw_enable_pin_in = 1'b1, step_up_enable_pin_in = 1'b1;
    reg        step_down_on_bit_in = 1'b1, step_up_on_bit_in = 1'b1;
    reg        power_up_done_in = 1'b0, pfm_step_down_in = 1'b0;
    reg        pfm_step_up_in = 1'b0;
    reg  [3:0] linreg_on_in = 4'hf;
    reg  [1:0] sequencer_command_in = 2'h2, hard_short_in = 2'h0;
    reg  [5:0] ovp_in = 6'h00, uvp_in = 6'h00, ocp_in = 6'h00;
    wire       wr_en_in, rd_en_in, rvalid_out, soft_reset_pulse_out;
    wire       step_down_load_out, step_up_load_out;
    wire [7:0] addr_in, wdata_in, rdata_out;
    wire [5:0] pulldown_out, fault_off_out;
    reg  [7:0] v;
    integer    fails = 0, checks_done = 0;
    always #10 clk_in = ~clk_in;
    host_model host_model_inst (.rdata_in(rdata_out), .clk_in(clk_in),
        .wr_en_out(wr_en_in), .rd_en_out(rd_en_in), .addr_out(addr_in),
        .wdata_out(wdata_in));
    pmic_discharge_reset_control pmic_discharge_reset_control_inst (.*);
    task check(input [7:0] seen, input [7:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("wrong value %0t %h %h", $time, seen, exp);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        host_model_inst.xfer(1'b1, a, d, v);
        check({7'h00, rvalid_out}, 8'h00);
    endtask
    task rchk(input [7:0] a, input [7:0] e);
        host_model_inst.xfer(1'b0, a, 8'h00, v);
        check({7'h00, rvalid_out}, 8'h01);
        check(v, e);
    endtask
    task t_regs;
        rchk(8'h0f, 8'h3f);
        rchk(8'h10, 8'h00);
        rchk(8'h33, 8'h00);
        $display("register map test done");
    endtask
    task look(input [1:0] s, input [7:0] e);
        repeat (3) @(posedge clk_in);
        #1 check(s == 0 ? {2'h0, pulldown_out} : s == 1 ? {2'h0, fault_off_out}
            : {6'h00, step_down_load_out, step_up_load_out}, e);
    endtask
    task t_dis;
        look(0, 8'h00);
        @(posedge clk_in) hw_enable_pin_in <= 1'b0;
        look(0, 8'h3d);
        @(posedge clk_in) hw_enable_pin_in <= 1'b1;
        ovp_in[1] <= 1'b1;
        look(0, 8'h02);
        @(posedge clk_in) ovp_in[1] <= 1'b0;
        step_up_enable_pin_in <= 1'b0;
        look(0, 8'h02);
        @(posedge clk_in) step_up_enable_pin_in <= 1'b1;
        step_down_on_bit_in <= 1'b0;
        step_up_on_bit_in <= 1'b0;
        look(0, 8'h03);
        @(posedge clk_in) step_down_on_bit_in <= 1'b1;
        step_up_on_bit_in <= 1'b1;
        sequencer_command_in <= 2'h1;
        sequencer_command_wr_in <= 1'b1;
        @(posedge clk_in) sequencer_command_wr_in <= 1'b0;
        look(0, 8'h00);
        @(posedge clk_in) sequencer_command_in <= 2'h2;
        sequencer_command_wr_in <= 1'b1;
        @(posedge clk_in) sequencer_command_wr_in <= 1'b0;
        look(0, 8'h3d);
        @(posedge clk_in) power_up_done_in <= 1'b1;
        @(posedge clk_in) power_up_done_in <= 1'b0;
        look(0, 8'h00);
        wr(8'h0f, 8'h00);
        @(posedge clk_in) hw_enable_pin_in <= 1'b0;
        look(0, 8'h00);
        @(posedge clk_in) hw_enable_pin_in <= 1'b1;
        $display("discharge test done");
    endtask
    task t_load;
        @(posedge clk_in) pfm_step_down_in <= 1'b1;
        pfm_step_up_in <= 1'b1;
        look(2, 8'h00);
        wr(8'h0f, 8'hc0);
        look(2, 8'h03);
        @(posedge clk_in) pfm_step_down_in <= 1'b0;
        look(2, 8'h01);
        $display("load test done");
    endtask
    task t_flt;
        @(posedge clk_in) uvp_in[2] <= 1'b1;
        look(1, 8'h04);
        @(posedge clk_in) uvp_in[2] <= 1'b0;
        linreg_on_in[0] <= 1'b0;
        wr(8'h10, 8'h01);
        @(posedge clk_in) linreg_on_in[0] <= 1'b1;
        ocp_in[0] <= 1'b1;
        look(1, 8'h00);
        @(posedge clk_in) hard_short_in[0] <= 1'b1;
        look(1, 8'h01);
        @(posedge clk_in) hard_short_in[0] <= 1'b0;
        ocp_in[0] <= 1'b0;
        $display("fault test done");
    endtask
    task t_soft;
        wr(8'h10, 8'h51);
        rchk(8'h0f, 8'hc0);
        rchk(8'h10, 8'h01);
        wr(8'h10, 8'h58);
        @(posedge clk_in);
        #1 check({7'h00, soft_reset_pulse_out}, 8'h01);
        @(posedge clk_in);
        #1 check({7'h00, soft_reset_pulse_out}, 8'h00);
        rchk(8'h0f, 8'h3f);
        rchk(8'h10, 8'h00);
        look(2, 8'h00);
        $display("soft reset test done");
    endtask
    task stop_test;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_regs;
        t_dis;
        t_load;
        t_flt;
        t_soft;
        stop_test;
    end
    initial
    begin
        #50000;
        fails = fails + 1;
        stop_test;
    end
endmodule // pmic_discharge_reset_control_tb
